/* core/emdm_params.svh */
// offsets, reset values and timing counts of the energy-mode manager
// assumes a 20 MHz system clock and a 32-bit apb register window
`ifndef EMDM_PARAMS_SVH
`define EMDM_PARAMS_SVH
// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define EMDM_OFF_CTRL 12'h000
`define EMDM_OFF_SCALE 12'h004
`define EMDM_OFF_RAM 12'h008
`define EMDM_OFF_SUPPLY 12'h00c
`define EMDM_OFF_STATUS 12'h010
// -----------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------
`define EMDM_SCALE_LOWEST 2'h0
`define EMDM_SCALE_MID 2'h1
`define EMDM_SCALE_FULL 2'h2
`define EMDM_RST_ACT_SCALE 2'h2
`define EMDM_RST_LOW_SCALE 2'h0
`define EMDM_RST_TARGET 3'h0
`define EMDM_RAM_BLOCKS 8
`define EMDM_RAMP_MAX 4'hf
`define EMDM_SUP_IRQ_EN 0
`define EMDM_SUP_BYPASS 1
`define EMDM_SUP_FLAG 2
// -----------------------------------------------------------------
// timing: times in ns, counts derived from the clock period
// -----------------------------------------------------------------
`define EMDM_CLK_NS 50
`define EMDM_SCALE_SETTLE_NS 10000
`define EMDM_PWRUP_NS 5000
`define EMDM_RAMP_STEP_NS 1000
`define EMDM_SCALE_CYC \
  ((`EMDM_SCALE_SETTLE_NS + `EMDM_CLK_NS - 1) / `EMDM_CLK_NS)
`define EMDM_PWRUP_CYC ((`EMDM_PWRUP_NS + `EMDM_CLK_NS - 1) / `EMDM_CLK_NS)
`define EMDM_STEP_CYC ((`EMDM_RAMP_STEP_NS + `EMDM_CLK_NS - 1) / `EMDM_CLK_NS)
`endif

/* core/emdm_pkg.sv */
// types shared by the energy-mode manager
// assumes the constants of emdm_params.svh
package emdm_pkg;
  typedef enum logic [2:0] {
    EMDM_LVL_ACTIVE = 3'h0,
    EMDM_LVL_SLEEP = 3'h1,
    EMDM_LVL_DEEP = 3'h2,
    EMDM_LVL_STOP = 3'h3,
    EMDM_LVL_OFF = 3'h4
  } emdm_level_t;

  typedef enum logic [5:0] {
    EMDM_ST_RUN = 6'h01,
    EMDM_ST_DOWN = 6'h02,
    EMDM_ST_LOW = 6'h04,
    EMDM_ST_OFF = 6'h08,
    EMDM_ST_SCALE_UP = 6'h10,
    EMDM_ST_PWR_UP = 6'h20
  } emdm_state_t;

  typedef struct packed {
    logic active;
    logic shared_aux;
    logic aux_d;
    logic aux_c;
    logic aux_b;
    logic base;
    logic always_on;
  } emdm_dom_t;
endpackage

/* core/emdm_top.sv */
// energy-mode manager: domain power, core scaling, ram and buck control
// assumes apb master on clk_sys, peripheral enables on clk_sys,
// wake and supply-low pins asynchronous to clk_sys
`timescale 1ns/1ps
`include "emdm_params.svh"

module emdm_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_sleep_req,
  input wire logic wake_pin,
  input wire logic supply_low_pin,
  input wire logic [2:0] aux_periph_en,
  input wire logic shared_periph_en,
  output emdm_pkg::emdm_dom_t dom_pwr,
  output logic [1:0] core_scale,
  output logic core_run,
  output logic clk_limit_40m,
  output logic [7:0] ram_pwr_on,
  output logic supply_low_irq,
  output logic buck_bypass,
  output logic [3:0] buck_ramp
);

  // -----------------------------------------------------------------
  // constants
  // -----------------------------------------------------------------
  localparam logic [8:0] SCALE_CYC = 9'(`EMDM_SCALE_CYC);
  localparam logic [8:0] PWRUP_CYC = 9'(`EMDM_PWRUP_CYC);
  localparam logic [4:0] STEP_CYC = 5'(`EMDM_STEP_CYC);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  emdm_pkg::emdm_state_t state_reg;
  emdm_pkg::emdm_state_t state_next;
  emdm_pkg::emdm_level_t level_reg;
  emdm_pkg::emdm_level_t level_next;
  emdm_pkg::emdm_level_t target_reg;
  emdm_pkg::emdm_dom_t dom_next;
  logic [8:0] tmr_reg;
  logic [8:0] tmr_next;
  logic [1:0] act_scale_reg;
  logic [1:0] low_scale_reg;
  logic [1:0] scale_next;
  logic [7:0] ram_off_reg;
  logic irq_en_reg;
  logic bypass_req_reg;
  logic flag_reg;
  logic [1:0] wake_sync_reg;
  logic [1:0] low_sync_reg;
  logic low_seen_reg;
  logic [4:0] div_reg;
  logic [3:0] ramp_reg;
  logic [3:0] ramp_next;
  logic bypass_next;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_sync_reg <= 2'h0;
      low_sync_reg <= 2'h0;
      low_seen_reg <= 1'b0;
    end
    else
    begin
      wake_sync_reg <= {wake_sync_reg[0], wake_pin};
      low_sync_reg <= {low_sync_reg[0], supply_low_pin};
      low_seen_reg <= low_sync_reg[1];
    end
  end

  wire wake = wake_sync_reg[1];
  wire supply_low_rise = low_sync_reg[1] & ~low_seen_reg;

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `EMDM_OFF_CTRL) || (a == `EMDM_OFF_SCALE) ||
                (a == `EMDM_OFF_RAM) || (a == `EMDM_OFF_SUPPLY) ||
                (a == `EMDM_OFF_STATUS);
  endfunction

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite & is_mapped(paddr);
  wire wr_ctrl = wr & (paddr == `EMDM_OFF_CTRL);
  wire wr_scale = wr & (paddr == `EMDM_OFF_SCALE);
  wire wr_ram = wr & (paddr == `EMDM_OFF_RAM);
  wire wr_sup = wr & (paddr == `EMDM_OFF_SUPPLY);

  assign pready = 1'b1;
  assign pslverr = access & ~is_mapped(paddr);

  // software may choose a new target but never a domain directly
  wire tgt_ok = pwdata[2:0] <= 3'(emdm_pkg::EMDM_LVL_OFF);
  // lowest scale is refused for the active group, reserved code too
  wire act_ok = (pwdata[1:0] == `EMDM_SCALE_MID) ||
                (pwdata[1:0] == `EMDM_SCALE_FULL);
  wire low_ok = pwdata[5:4] != 2'h3;

  wire [31:0] rd_status = {
    4'h0, ramp_reg, 2'h0, buck_bypass, core_run,
    2'h0, core_scale, 1'b0, dom_pwr, 5'h0, level_reg
  };

  wire [31:0] rd_mux =
    (paddr == `EMDM_OFF_CTRL) ? {29'h0, target_reg} :
    (paddr == `EMDM_OFF_SCALE) ? {26'h0, low_scale_reg, 2'h0,
                                 act_scale_reg} :
    (paddr == `EMDM_OFF_RAM) ? {24'h0, ram_off_reg} :
    (paddr == `EMDM_OFF_SUPPLY) ? {29'h0, flag_reg, bypass_req_reg,
                                  irq_en_reg} :
    (paddr == `EMDM_OFF_STATUS) ? rd_status : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h0;
    else if (setup && !pwrite)
      prdata <= rd_mux;
  end

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      target_reg <= emdm_pkg::emdm_level_t'(`EMDM_RST_TARGET);
      act_scale_reg <= `EMDM_RST_ACT_SCALE;
      low_scale_reg <= `EMDM_RST_LOW_SCALE;
      ram_off_reg <= 8'h0;
      irq_en_reg <= 1'b0;
      bypass_req_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && tgt_ok)
        target_reg <= emdm_pkg::emdm_level_t'(pwdata[2:0]);
      if (wr_scale && act_ok)
        act_scale_reg <= pwdata[1:0];
      if (wr_scale && low_ok)
        low_scale_reg <= pwdata[5:4];
      if (wr_ram)
        ram_off_reg <= pwdata[7:0];
      if (wr_sup)
      begin
        irq_en_reg <= pwdata[`EMDM_SUP_IRQ_EN];
        bypass_req_reg <= pwdata[`EMDM_SUP_BYPASS];
      end
    end
  end

  // -----------------------------------------------------------------
  // supply-low flag: set wins over write-one-to-clear
  // -----------------------------------------------------------------
  wire flag_clr = wr_sup & pwdata[`EMDM_SUP_FLAG];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      flag_reg <= 1'b0;
    else if (supply_low_rise)
      flag_reg <= 1'b1;
    else if (flag_clr)
      flag_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      supply_low_irq <= 1'b0;
    else
      supply_low_irq <= (flag_reg | supply_low_rise) & irq_en_reg;
  end

  // -----------------------------------------------------------------
  // mode sequencer
  // -----------------------------------------------------------------
  wire tmr_done = tmr_reg == 9'h0;
  wire to_low = core_sleep_req && (target_reg != emdm_pkg::EMDM_LVL_ACTIVE)
                && (target_reg != emdm_pkg::EMDM_LVL_SLEEP);
  wire to_sleep = core_sleep_req &&
                  (target_reg == emdm_pkg::EMDM_LVL_SLEEP);

  always_comb
  begin
    state_next = state_reg;
    level_next = level_reg;
    tmr_next = tmr_done ? 9'h0 : tmr_reg - 9'h1;
    case (state_reg)
      emdm_pkg::EMDM_ST_RUN:
      begin
        if (to_low)
        begin
          // core halts and active domain drops at once
          state_next = emdm_pkg::EMDM_ST_DOWN;
          level_next = target_reg;
          tmr_next = SCALE_CYC;
        end
        else if (to_sleep)
          level_next = emdm_pkg::EMDM_LVL_SLEEP;
        else if (wake && level_reg == emdm_pkg::EMDM_LVL_SLEEP)
          level_next = emdm_pkg::EMDM_LVL_ACTIVE;
      end
      emdm_pkg::EMDM_ST_DOWN:
      begin
        if (tmr_done)
          state_next = (level_reg == emdm_pkg::EMDM_LVL_OFF) ?
                       emdm_pkg::EMDM_ST_OFF : emdm_pkg::EMDM_ST_LOW;
      end
      emdm_pkg::EMDM_ST_LOW, emdm_pkg::EMDM_ST_OFF:
      begin
        if (wake)
        begin
          state_next = emdm_pkg::EMDM_ST_SCALE_UP;
          tmr_next = SCALE_CYC;
        end
      end
      emdm_pkg::EMDM_ST_SCALE_UP:
      begin
        if (tmr_done)
        begin
          state_next = emdm_pkg::EMDM_ST_PWR_UP;
          tmr_next = PWRUP_CYC;
        end
      end
      emdm_pkg::EMDM_ST_PWR_UP:
      begin
        if (tmr_done)
        begin
          state_next = emdm_pkg::EMDM_ST_RUN;
          level_next = emdm_pkg::EMDM_LVL_ACTIVE;
        end
      end
      default:
      begin
        state_next = emdm_pkg::EMDM_ST_RUN;
        level_next = emdm_pkg::EMDM_LVL_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= emdm_pkg::EMDM_ST_RUN;
      level_reg <= emdm_pkg::EMDM_LVL_ACTIVE;
      tmr_reg <= 9'h0;
    end
    else
    begin
      state_reg <= state_next;
      level_reg <= level_next;
      tmr_reg <= tmr_next;
    end
  end

  // -----------------------------------------------------------------
  // domain power and scaling, derived from next state
  // -----------------------------------------------------------------
  wire nx_run = state_next == emdm_pkg::EMDM_ST_RUN;
  wire nx_pwr_up = state_next == emdm_pkg::EMDM_ST_PWR_UP;
  wire nx_scale_up = state_next == emdm_pkg::EMDM_ST_SCALE_UP;
  wire nx_off = state_next == emdm_pkg::EMDM_ST_OFF;
  wire nx_active_grp = nx_run | nx_pwr_up | nx_scale_up;

  assign dom_next.always_on = 1'b1;
  assign dom_next.base = ~nx_off;
  assign dom_next.aux_b = ~nx_off & aux_periph_en[0];
  assign dom_next.aux_c = ~nx_off & aux_periph_en[1];
  assign dom_next.aux_d = ~nx_off & aux_periph_en[2];
  assign dom_next.shared_aux = ~nx_off &
    (shared_periph_en | (|aux_periph_en));
  // everything else of the chip, core included, sits on this rail
  assign dom_next.active = nx_run | nx_pwr_up;

  assign scale_next = nx_active_grp ? act_scale_reg : low_scale_reg;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dom_pwr <= '{default: 1'b1};
      core_scale <= `EMDM_RST_ACT_SCALE;
      core_run <= 1'b1;
      ram_pwr_on <= 8'hff;
    end
    else
    begin
      dom_pwr <= dom_next;
      core_scale <= scale_next;
      core_run <= nx_run;
      ram_pwr_on <= ~ram_off_reg;
    end
  end

  // core clock must stay at or below 40 MHz while mid scale applies
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      clk_limit_40m <= 1'b0;
    else
      clk_limit_40m <= nx_active_grp &&
                       (act_scale_reg == `EMDM_SCALE_MID);
  end

  // -----------------------------------------------------------------
  // buck soft switching
  // -----------------------------------------------------------------
  wire step_en = div_reg == 5'h0;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      div_reg <= 5'h0;
    else
      div_reg <= step_en ? STEP_CYC - 5'h1 : div_reg - 5'h1;
  end

  // ramp climbs from zero after reset, falls before bypass engages
  always_comb
  begin
    ramp_next = ramp_reg;
    bypass_next = buck_bypass;
    if (bypass_req_reg)
    begin
      if (ramp_reg != 4'h0 && step_en)
        ramp_next = ramp_reg - 4'h1;
      if (ramp_reg == 4'h0)
        bypass_next = 1'b1;
    end
    else
    begin
      bypass_next = 1'b0;
      if (ramp_reg != `EMDM_RAMP_MAX && step_en)
        ramp_next = ramp_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ramp_reg <= 4'h0;
      buck_bypass <= 1'b0;
    end
    else
    begin
      ramp_reg <= ramp_next;
      buck_bypass <= bypass_next;
    end
  end

  assign buck_ramp = ramp_reg;

endmodule

/* tb/emdm_core_model.sv */
// core-side model: sleep requests and a held wake pin
// assumes one-cycle commands from the bench on clk_sys
`timescale 1ns/1ps
module emdm_core_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic core_run,
  input wire logic sleep_cmd,
  input wire logic wake_cmd,
  output logic core_sleep_req,
  output logic wake_pin
);
  logic [2:0] held_reg;
  // ----
  // sleep asked only while running; wake held until the core has run for eight cycles
  // ----
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      core_sleep_req <= 1'h0;
      wake_pin <= 1'h0;
      held_reg <= 3'h0;
    end
    else
    begin
      core_sleep_req <= sleep_cmd & core_run;
      held_reg <= (wake_pin & core_run) ? held_reg + 3'h1 : 3'h0;
      wake_pin <= wake_cmd | (wake_pin & held_reg != 3'h7);
    end
endmodule

/* tb/emdm_top_properties.sv */
// concurrent checks on the energy-mode manager ports
// assumes one clock domain and a bind onto emdm_top
`timescale 1ns/1ps
module emdm_top_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] aux_periph_en,
  input wire emdm_pkg::emdm_dom_t dom_pwr,
  input wire logic [1:0] core_scale,
  input wire logic core_run,
  input wire logic clk_limit_40m,
  input wire logic buck_bypass,
  input wire logic [3:0] buck_ramp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----
  // domain power, wake order, clock limit and buck bypass
  // ----
  sequence s_act_rise;
    $rose(dom_pwr.active);
  endsequence
  sequence s_run_held;
    !core_run [*8];
  endsequence
  chk_aon_kept: assert property (dom_pwr.always_on)
    else $error("always-on domain unpowered");
  chk_off_all: assert property (
    !dom_pwr.base |-> dom_pwr[6:1] == 6'h00)
    else $error("domain powered while base is off");
  chk_shared_aux: assert property (
    (dom_pwr.aux_b | dom_pwr.aux_c | dom_pwr.aux_d) |-> dom_pwr.shared_aux)
    else $error("shared aux off while an aux is on");
  chk_aux_follow: assert property (
    dom_pwr.base && $past(dom_pwr.base) && $past(rst_b) |->
    {dom_pwr.aux_d, dom_pwr.aux_c, dom_pwr.aux_b} == $past(aux_periph_en))
    else $error("aux domains do not follow enables");
  chk_sleep_drop: assert property (
    $fell(core_run) |-> !dom_pwr.active)
    else $error("active domain kept after core halt");
  chk_wake_order: assert property (s_act_rise |=> s_run_held)
    else $error("core released too soon after power-up");
  chk_run_late: assert property (
    $rose(core_run) |-> $past(dom_pwr.active, 100))
    else $error("core released before domain settled");
  chk_run_act: assert property (core_run |-> dom_pwr.active)
    else $error("core runs without active domain");
  chk_mid_limit: assert property (
    clk_limit_40m |-> core_scale == 2'h1)
    else $error("clock limit without mid scale");
  chk_bypass_ramp: assert property (
    buck_bypass |-> buck_ramp == 4'h0)
    else $error("bypass entered before ramp-down");
endmodule
bind emdm_top emdm_top_chk chk_u (.clk_sys, .rst_b, .aux_periph_en,
  .dom_pwr, .core_scale, .core_run, .clk_limit_40m, .buck_bypass,
  .buck_ramp);

/* tb/tb_emdm_top.sv */
// self-checking bench for the energy-mode manager
// assumes emdm_top, its checker and the core model
`timescale 1ns/1ps
`include "emdm_params.svh"
module tb_emdm_top;
  logic clk_sys = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, supply_low_pin = 1'h0, shared_periph_en = 1'h0;
  logic sleep_cmd = 1'h0, wake_cmd = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'he2c16599;
  logic [2:0] aux_periph_en = 3'h0;
  logic pready, pslverr, er, core_sleep_req, wake_pin, core_run;
  logic clk_limit_40m, supply_low_irq, buck_bypass;
  emdm_pkg::emdm_dom_t dom_pwr;
  logic [1:0] core_scale;
  logic [7:0] ram_pwr_on;
  logic [3:0] buck_ramp;
  int fails = 0, comparisons = 0, lvl_q[$] = '{2, 3, 4};
  always #25 clk_sys = ~clk_sys;
  emdm_top dut_u (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_sleep_req, .wake_pin,
    .supply_low_pin, .aux_periph_en, .shared_periph_en, .dom_pwr,
    .core_scale, .core_run, .clk_limit_40m, .ram_pwr_on, .supply_low_irq,
    .buck_bypass, .buck_ramp);
  emdm_core_model core_u (.clk_sys, .rst_b, .core_run, .sleep_cmd,
    .wake_cmd, .core_sleep_req, .wake_pin);
  // ----
  // reference model and helpers
  // ----
  function automatic emdm_pkg::emdm_dom_t exp_dom(input int off, act,
    input logic [2:0] en, input logic sh);
    emdm_pkg::emdm_dom_t d;
    d.always_on = 1'h1;
    d.base = (off == 0);
    {d.aux_d, d.aux_c, d.aux_b} = (off == 0) ? en : 3'h0;
    d.shared_aux = (off == 0) && (sh || en != 3'h0);
    d.active = (act != 0);
    return d;
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1)
      @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pulse(input logic wk);
    @(posedge clk_sys);
    wake_cmd <= wk;
    sleep_cmd <= !wk;
    @(posedge clk_sys);
    wake_cmd <= 1'h0;
    sleep_cmd <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rand_en(input int off, act);
    lfsr = lfsr_next(lfsr);
    @(posedge clk_sys);
    aux_periph_en <= lfsr[2:0];
    shared_periph_en <= lfsr[3];
    @(posedge clk_sys);
    #1 chk(dom_pwr, exp_dom(off, act, lfsr[2:0], lfsr[3]));
  endtask
  task automatic give_verdict;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fails++;
    give_verdict;
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'h1;
    apb(1'h0, `EMDM_OFF_SCALE, 32'h0);
    chk(rd, 32'h2);
    apb(1'h0, 12'h0fc, 32'h0);
    chk(er, 1'h1);
    apb(1'h1, `EMDM_OFF_RAM, 32'ha5);
    repeat (2) @(posedge clk_sys);
    #1 chk(ram_pwr_on, 8'h5a);
    apb(1'h1, `EMDM_OFF_SCALE, 32'h13);
    apb(1'h0, `EMDM_OFF_SCALE, 32'h0);
    chk(rd, 32'h12);
    apb(1'h1, `EMDM_OFF_SCALE, 32'h01);
    apb(1'h0, `EMDM_OFF_SCALE, 32'h0);
    chk(rd, 32'h01);
    repeat (6) rand_en(0, 1);
    apb(1'h1, `EMDM_OFF_CTRL, 32'h1);
    pulse(1'h0);
    apb(1'h0, `EMDM_OFF_STATUS, 32'h0);
    chk({rd[20], rd[14], rd[2:0]}, 5'h19);
    pulse(1'h1);
    repeat (8) @(posedge clk_sys);
    apb(1'h0, `EMDM_OFF_STATUS, 32'h0);
    chk(rd[2:0], 3'h0);
    foreach (lvl_q[i])
    begin
      apb(1'h1, `EMDM_OFF_CTRL, 32'(lvl_q[i]));
      pulse(1'h0);
      #1 chk({core_run, dom_pwr.active, core_scale}, 4'h0);
      repeat (205) @(posedge clk_sys);
      repeat (2) rand_en(lvl_q[i] == 4, 0);
      pulse(1'h1);
      while (core_run !== 1'h1)
        @(posedge clk_sys);
      #1 chk({dom_pwr.active, core_scale, clk_limit_40m}, 4'hb);
      apb(1'h0, `EMDM_OFF_STATUS, 32'h0);
      chk({rd[27:21], rd[2:0]}, 10'h3c0);
      repeat (8) @(posedge clk_sys);
    end
    apb(1'h1, `EMDM_OFF_SUPPLY, 32'h1);
    supply_low_pin <= 1'h1;
    repeat (6) @(posedge clk_sys);
    #1 chk(supply_low_irq, 1'h1);
    apb(1'h0, `EMDM_OFF_SUPPLY, 32'h0);
    chk(rd[2:0], 3'h5);
    apb(1'h1, `EMDM_OFF_SUPPLY, 32'h0);
    supply_low_pin <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1 chk(supply_low_irq, 1'h0);
    apb(1'h1, `EMDM_OFF_SUPPLY, 32'h4);
    apb(1'h1, `EMDM_OFF_SUPPLY, 32'h2);
    apb(1'h0, `EMDM_OFF_SUPPLY, 32'h0);
    chk(rd[2:0], 3'h2);
    while (buck_bypass !== 1'h1)
      @(posedge clk_sys);
    #1 chk(buck_ramp, 4'h0);
    give_verdict;
  end
endmodule
